/* File: common/smof_pkg.sv */
// Purpose: shared constants and types of the serial measurement formatter
// Assumes: 125 MHz clock, 32-bit register words on AXI4-Lite
// Notes:   every offset, control field position and timing figure lives here
package smof_pkg;
   localparam int          CLK_HZ       = 125_000_000;
   localparam int          BAUD_DEFAULT = 115_200;
   localparam logic [15:0] BAUD_RESET   = 16'(CLK_HZ / BAUD_DEFAULT);
   localparam int          DATA_BITS    = 8;
   localparam int          STOP_BITS    = 2;
   localparam int          CHAR_LIMIT   = 160;
   localparam int          BIN_BYTES    = 4;
   localparam int          DEC_DIGITS   = 10;
   localparam int          ADDR_W       = 8;

   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_MINW   = 8'h04;
   localparam logic [7:0] OFF_BAUD   = 8'h08;
   localparam logic [7:0] OFF_VSEP   = 8'h0c;
   localparam logic [7:0] OFF_MSEP   = 8'h10;
   localparam logic [7:0] OFF_ORDER  = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   localparam int CTRL_BIN   = 0;
   localparam int CTRL_PRE   = 1;
   localparam int CTRL_COND  = 2;
   localparam int CTRL_CHAN  = 4;
   localparam int CTRL_VMODE = 8;
   localparam int CTRL_MMODE = 10;
   localparam int CTRL_VLEN  = 12;
   localparam int CTRL_MLEN  = 14;
   localparam int CTRL_CNT   = 16;
   localparam int ORDER_W    = 4;

   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   localparam logic [7:0]  MINW_RESET  = 8'h00;
   localparam logic [31:0] SEP_RESET   = 32'h0000_0000;
   localparam logic [31:0] ORDER_RESET = 32'h7654_3210;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   localparam logic [7:0] CH_TAB   = 8'h09;
   localparam logic [7:0] CH_LF    = 8'h0a;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_ZERO  = 8'h30;

   typedef enum logic [1:0] {SEP_TAB = 2'h0, SEP_LF = 2'h1, SEP_USER = 2'h2} smof_sep_type;
   typedef enum logic [1:0] {COND_ALWAYS = 2'h0, COND_FAIL = 2'h1, COND_PASS = 2'h2} smof_cond_type;

   // source slot numbers on the measurement input
   localparam int SRC_PROGRAM  = 0;
   localparam int SRC_COMBINED = 1;
   localparam int SRC_TEMP     = 2;
   localparam int SRC_LASER    = 3;
   localparam int SRC_USERMODE = 4;
   localparam int SRC_FILTERED = 5;
   localparam int SRC_ERROR    = 6;
   localparam int SRC_PROFILE  = 7;
   localparam int SRC_DOUT     = 8;
   localparam int SRC_ENCODER  = 9;

   localparam logic [31:0] POW10 [0:DEC_DIGITS-1] = '{32'h0000_0001, 32'h0000_000a,
      32'h0000_0064, 32'h0000_03e8, 32'h0000_2710, 32'h0001_86a0, 32'h000f_4240,
      32'h0098_9680, 32'h05f5_e100, 32'h3b9a_ca00};
endpackage

/* File: src/smof_uart_tx.sv */
// Purpose: asynchronous serial character transmitter, fixed frame
// Assumes: baud_div is the bit period in clock cycles
// Notes:   one start bit, eight data bits lsb first, two stop bits
`timescale 1ns/1ns
`default_nettype none
module smof_uart_tx
   import smof_pkg::*;
(
   input  wire logic        aclk,      // system clock
   input  wire logic        aresetn,   // sync reset, active low
   input  wire logic [15:0] baud_div,  // cycles per bit
   input  wire logic        tx_start,  // take tx_data when ready
   input  wire logic [7:0]  tx_data,   // character to send
   output logic             tx_ready,  // idle, may start
   output logic             txd        // serial line, idles high
);
   localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;

   logic [15:0]               baud_cnt;
   logic                      baud_tick;
   logic [3:0]                bits_left;
   logic [FRAME_BITS-2:0]     shift;

   assign tx_ready  = (bits_left == 4'h0);
   // a zero divisor behaves as one cycle per bit
   assign baud_tick = ({1'b0, baud_cnt} + 17'h1_0001 - 17'h1_0000) >= {1'b0, baud_div};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bits_left <= 4'h0;
         baud_cnt  <= 16'h0000;
         shift     <= '1;
         txd       <= 1'b1;
      end else if (tx_ready && tx_start) begin
         txd       <= 1'b0;
         shift     <= {{STOP_BITS{1'b1}}, tx_data};
         bits_left <= 4'(FRAME_BITS);
         baud_cnt  <= 16'h0000;
      end else if (!tx_ready) begin
         if (baud_tick) begin
            baud_cnt  <= 16'h0000;
            bits_left <= bits_left - 4'h1;
            txd       <= shift[0];
            shift     <= {1'b1, shift[FRAME_BITS-2:1]};
         end else begin
            baud_cnt <= baud_cnt + 16'h0001;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_start_bit_low: assert property (tx_start && tx_ready |=> !txd && !tx_ready)
      else $error("start bit not driven low");
   chk_idle_line_high: assert property (tx_ready |-> txd)
      else $error("line not high while idle");
   chk_two_stop_bits: assert property (bits_left inside {4'h1, 4'h2} |-> txd)
      else $error("stop bit not high");
endmodule // smof_uart_tx
`default_nettype wire

/* File: src/smof_formatter.sv */
// Purpose: formats measurement values and sends them on the serial link
// Assumes: measurement inputs come from logic on aclk; AXI4-Lite registers
// Notes:   a measurement arriving while one is still being sent is counted
//          as overrun and dropped
//
// Summary of operation
// - frame is 8 data, no parity, 2 stop
// - baud rate set by divisor register
// - text value padded with leading spaces
// - longer text values sent whole, untruncated
// - control bit picks text or binary
// - value separator after every value
// - measurement separator delimits each measurement
// - prefix set: separator before the values
// - prefix clear: separator after the values
// - binary: no value separator, no padding
// - binary words sent most significant first
// - unconditional mode sends every measurement
// - fail mode sends only failing verdicts
// - pass mode sends only passing verdicts
// - at most 160 characters per measurement
// - values sent raw, unscaled
// - values follow the configured order list
// - ten source kinds selectable
`timescale 1ns/1ns
`default_nettype none
module smof_formatter
   import smof_pkg::*;
#(
   parameter int NSRC  = 16,   // source slots on meas_values
   parameter int NCHAN = 8     // digital output verdict channels
)(
   input  wire logic               aclk,           // system clock
   input  wire logic               aresetn,        // sync reset, active low
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,   // write address
   input  wire logic [2:0]         s_axi_awprot,   // unused
   input  wire logic               s_axi_awvalid,  // write address valid
   output logic                    s_axi_awready,  // write address ready
   input  wire logic [31:0]        s_axi_wdata,    // write data
   input  wire logic [3:0]         s_axi_wstrb,    // byte enables
   input  wire logic               s_axi_wvalid,   // write data valid
   output logic                    s_axi_wready,   // write data ready
   output logic [1:0]              s_axi_bresp,    // write response
   output logic                    s_axi_bvalid,   // write response valid
   input  wire logic               s_axi_bready,   // write response ready
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,   // read address
   input  wire logic [2:0]         s_axi_arprot,   // unused
   input  wire logic               s_axi_arvalid,  // read address valid
   output logic                    s_axi_arready,  // read address ready
   output logic [31:0]             s_axi_rdata,    // read data
   output logic [1:0]              s_axi_rresp,    // read response
   output logic                    s_axi_rvalid,   // read data valid
   input  wire logic               s_axi_rready,   // read data ready
   input  wire logic               meas_valid,     // measurement complete pulse
   input  wire logic [NSRC*32-1:0] meas_values,    // raw source words
   input  wire logic [NCHAN-1:0]   fail_verdict,   // 1 = channel judged failing
   output logic                    txd,            // serial output
   output logic                    busy            // measurement in progress
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_LEAD = 3'b001, ST_CONV = 3'b011, ST_PAD = 3'b010,
      ST_DIG  = 3'b110, ST_VSEP = 3'b111, ST_BIN  = 3'b101, ST_TAIL = 3'b100
   } smof_state_type;

   logic [31:0]     ctrl;
   logic [7:0]      minw;
   logic [15:0]     baud_div;
   logic [31:0]     vsep_chars;
   logic [31:0]     msep_chars;
   logic [31:0]     order;
   logic [15:0]     overrun_cnt;
   logic [7:0]      char_cnt;
   logic            aw_got;
   logic            w_got;
   logic [7:0]      aw_addr;
   logic [31:0]     w_data;
   logic [3:0]      w_strb;
   smof_state_type  state;
   logic [3:0]      slot;
   logic [7:0]      cnt;
   logic [31:0]     vals [NSRC];
   logic [31:0]     rem;
   logic [3:0]      pow_idx;
   logic            primed;
   logic [3:0]      digits [DEC_DIGITS];
   logic [3:0]      ndig;
   logic [7:0]      pad_need;
   logic [7:0]      cur_char;
   logic [31:0]     sel_value;
   logic            conv_done;
   logic            emitting;
   logic            over_limit;
   logic            advance;
   logic            tx_start;
   logic            tx_ready;
   logic            gate_ok;
   logic            is_binary;
   logic            prefix;
   logic [1:0]      cond;
   logic [2:0]      chan;
   logic [1:0]      vmode;
   logic [1:0]      mmode;
   logic [1:0]      vlast;
   logic [1:0]      mlast;
   logic [3:0]      list_cnt;

   assign is_binary = ctrl[CTRL_BIN];
   assign prefix    = ctrl[CTRL_PRE];
   assign cond      = ctrl[CTRL_COND +: 2];
   assign chan      = ctrl[CTRL_CHAN +: 3];
   assign vmode     = ctrl[CTRL_VMODE +: 2];
   assign mmode     = ctrl[CTRL_MMODE +: 2];
   assign list_cnt  = (ctrl[CTRL_CNT +: 4] > 4'h8) ? 4'h8 : ctrl[CTRL_CNT +: 4];
   assign vlast     = (vmode == SEP_USER) ? ctrl[CTRL_VLEN +: 2] : 2'h0;
   assign mlast     = (mmode == SEP_USER) ? ctrl[CTRL_MLEN +: 2] : 2'h0;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[8*i +: 8] = d[8*i +: 8];
      end
      return r;
   endfunction

   function automatic logic [7:0] sep_char(input logic [1:0] mode, input logic [31:0] chars,
                                           input logic [1:0] idx);
      logic [7:0] c;
      c = chars[8*idx +: 8];
      if (mode == SEP_TAB) c = CH_TAB;
      else if (mode == SEP_LF) c = CH_LF;
      return c;
   endfunction

   // next state after the measurement start or a finished value
   function automatic smof_state_type entry(input logic [3:0] s);
      smof_state_type n;
      if (s >= list_cnt) n = prefix ? ST_IDLE : ST_TAIL;
      else n = is_binary ? ST_BIN : ST_CONV;
      return n;
   endfunction

   // register bus: write address and data may arrive in either order
   assign s_axi_awready = !aw_got && !s_axi_bvalid;
   assign s_axi_wready  = !w_got && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got  <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got  <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_got && w_got) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[7:2] <= OFF_STATUS[7:2]) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl       <= CTRL_RESET;
         minw       <= MINW_RESET;
         baud_div   <= BAUD_RESET;
         vsep_chars <= SEP_RESET;
         msep_chars <= SEP_RESET;
         order      <= ORDER_RESET;
      end else if (aw_got && w_got) begin
         unique case ({aw_addr[7:2], 2'b00})
            OFF_CTRL:  ctrl       <= merge(ctrl, w_data, w_strb);
            OFF_MINW:  if (w_strb[0]) minw <= w_data[7:0];
            OFF_BAUD:  baud_div   <= 16'(merge({16'h0000, baud_div}, w_data, w_strb));
            OFF_VSEP:  vsep_chars <= merge(vsep_chars, w_data, w_strb);
            OFF_MSEP:  msep_chars <= merge(msep_chars, w_data, w_strb);
            OFF_ORDER: order      <= merge(order, w_data, w_strb);
            default:   ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         unique case ({s_axi_araddr[7:2], 2'b00})
            OFF_CTRL:   s_axi_rdata <= ctrl;
            OFF_MINW:   s_axi_rdata <= {24'h00_0000, minw};
            OFF_BAUD:   s_axi_rdata <= {16'h0000, baud_div};
            OFF_VSEP:   s_axi_rdata <= vsep_chars;
            OFF_MSEP:   s_axi_rdata <= msep_chars;
            OFF_ORDER:  s_axi_rdata <= order;
            OFF_STATUS: s_axi_rdata <= {overrun_cnt, char_cnt, 7'h00, busy};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // verdict gating
   always_comb begin
      unique case (cond)
         COND_ALWAYS: gate_ok = 1'b1;
         COND_FAIL:   gate_ok = fail_verdict[chan];
         COND_PASS:   gate_ok = !fail_verdict[chan];
         default:     gate_ok = 1'b0;
      endcase
   end

   // snapshot taken at acceptance so later inputs cannot tear a measurement
   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_snap
         always_ff @(posedge aclk) begin
            if (!aresetn) vals[g] <= 32'h0000_0000;
            else if (state == ST_IDLE && meas_valid) vals[g] <= meas_values[32*g +: 32];
         end
      end
   endgenerate

   assign sel_value = vals[order[ORDER_W*slot[2:0] +: ORDER_W]];

   // decimal conversion by repeated subtraction of powers of ten
   always_ff @(posedge aclk) begin
      if (!aresetn || state != ST_CONV) begin
         primed <= 1'b0;
      end else if (!primed) begin
         primed  <= 1'b1;
         rem     <= sel_value;
         pow_idx <= 4'(DEC_DIGITS - 1);
         for (int i = 0; i < DEC_DIGITS; i++) digits[i] <= 4'h0;
      end else if (rem >= POW10[pow_idx]) begin
         rem             <= rem - POW10[pow_idx];
         digits[pow_idx] <= digits[pow_idx] + 4'h1;
      end else if (pow_idx != 4'h0) begin
         pow_idx <= pow_idx - 4'h1;
      end
   end

   assign conv_done = primed && (pow_idx == 4'h0) && (rem == 32'h0000_0000);

   always_comb begin
      ndig = 4'h1;
      for (int i = 1; i < DEC_DIGITS; i++) begin
         if (digits[i] != 4'h0) ndig = 4'(i + 1);
      end
   end

   assign pad_need = (minw > {4'h0, ndig}) ? minw - {4'h0, ndig} : 8'h00;

   always_comb begin
      unique case (state)
         ST_LEAD, ST_TAIL: cur_char = sep_char(mmode, msep_chars, cnt[1:0]);
         ST_VSEP:          cur_char = sep_char(vmode, vsep_chars, cnt[1:0]);
         ST_PAD:           cur_char = CH_SPACE;
         ST_DIG:           cur_char = CH_ZERO + {4'h0, digits[cnt[3:0]]};
         ST_BIN:           cur_char = sel_value[8*(2'd3 - cnt[1:0]) +: 8];
         default:          cur_char = 8'h00;
      endcase
   end

   assign emitting   = (state != ST_IDLE) && (state != ST_CONV);
   assign over_limit = (char_cnt >= 8'(CHAR_LIMIT));
   // past the limit characters are skipped at full speed, not sent
   assign advance    = emitting && (over_limit || tx_ready);
   assign tx_start   = emitting && !over_limit && tx_ready;
   assign busy       = (state != ST_IDLE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         char_cnt    <= 8'h00;
         overrun_cnt <= 16'h0000;
      end else begin
         if (state == ST_IDLE && meas_valid && gate_ok) char_cnt <= 8'h00;
         else if (tx_start) char_cnt <= char_cnt + 8'h01;
         if (busy && meas_valid) overrun_cnt <= overrun_cnt + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         slot  <= 4'h0;
         cnt   <= 8'h00;
      end else begin
         unique case (state)
            ST_IDLE: if (meas_valid && gate_ok) begin
               slot  <= 4'h0;
               cnt   <= 8'h00;
               state <= prefix ? ST_LEAD : entry(4'h0);
            end
            ST_LEAD: if (advance) begin
               if (cnt[1:0] == mlast) begin
                  cnt   <= 8'h00;
                  state <= entry(4'h0);
               end else cnt <= cnt + 8'h01;
            end
            ST_CONV: if (conv_done) begin
               state <= (pad_need != 8'h00) ? ST_PAD : ST_DIG;
               cnt   <= (pad_need != 8'h00) ? 8'h00 : {4'h0, ndig - 4'h1};
            end
            ST_PAD: if (advance) begin
               if (cnt == pad_need - 8'h01) begin
                  cnt   <= {4'h0, ndig - 4'h1};
                  state <= ST_DIG;
               end else cnt <= cnt + 8'h01;
            end
            ST_DIG: if (advance) begin
               if (cnt == 8'h00) state <= ST_VSEP;
               else cnt <= cnt - 8'h01;
            end
            ST_VSEP, ST_BIN: if (advance) begin
               if ((state == ST_VSEP && cnt[1:0] == vlast) ||
                   (state == ST_BIN && cnt == 8'(BIN_BYTES - 1))) begin
                  cnt   <= 8'h00;
                  slot  <= slot + 4'h1;
                  state <= entry(slot + 4'h1);
               end else cnt <= cnt + 8'h01;
            end
            ST_TAIL: if (advance) begin
               if (cnt[1:0] == mlast) state <= ST_IDLE;
               else cnt <= cnt + 8'h01;
            end
         endcase
      end
   end

   smof_uart_tx u_tx (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .baud_div (baud_div),
      .tx_start (tx_start),
      .tx_data  (cur_char),
      .tx_ready (tx_ready),
      .txd      (txd)
   );

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_char_limit: assert property (tx_start |-> char_cnt < 8'(CHAR_LIMIT))
      else $error("character sent beyond limit");
   chk_fail_gate: assert property (state == ST_IDLE && meas_valid && cond == COND_FAIL
      && !fail_verdict[chan] |=> state == ST_IDLE)
      else $error("fail mode sent a passing measurement");
   chk_pass_gate: assert property (state == ST_IDLE && meas_valid && cond == COND_PASS
      && fail_verdict[chan] |=> state == ST_IDLE)
      else $error("pass mode sent a failing measurement");
   chk_always_start: assert property (state == ST_IDLE && meas_valid && cond == COND_ALWAYS
      |=> busy)
      else $error("unconditional measurement not started");
   chk_prefix_lead: assert property (state == ST_IDLE && meas_valid && gate_ok && prefix
      |=> state == ST_LEAD)
      else $error("leading separator missing");
   chk_pad_space: assert property (state == ST_PAD |-> !is_binary && cur_char == CH_SPACE)
      else $error("padding wrong or in binary");
   chk_binary_plain: assert property (is_binary && $stable(ctrl) |-> state != ST_VSEP)
      else $error("value separator in binary");
   chk_bin_msb_first: assert property (state == ST_BIN && cnt == 8'h00 && tx_start
      |-> cur_char == sel_value[31:24])
      else $error("binary word not msb first");
   chk_write_resp: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule // smof_formatter
`default_nettype wire

/* File: verification/smof_rx_model.sv */
// Purpose: remote serial listener model
// Assumes: DIV clock cycles per bit
// Notes:   a low stop bit bumps ferr
`timescale 1ns/1ns
`default_nettype none
module smof_rx_model #(parameter int DIV = 4) (
   input wire logic aclk, // system clock
   input wire logic txd   // line from device
);
   logic [7:0] q[$];
   int         ferr = 0;
   logic [7:0] b;
   initial forever begin
      @(posedge aclk);
      if (txd === 1'b0) begin // low start, lsb first
         repeat (DIV / 2) @(posedge aclk);
         for (int i = 0; i < 10; i++) begin // 8 data, no parity, 2 stop
            repeat (DIV) @(posedge aclk);
            if (i < 8) b[i] = txd;
            else if (txd !== 1'b1) ferr++;
         end
         q.push_back(b);
      end
   end
endmodule // smof_rx_model
`default_nettype wire

/* File: verification/tb_smof_formatter.sv */
// Purpose: self-checking bench of the serial formatter
// Assumes: baud divisor cut to 4 cycles to keep runs short
// Notes:   expected bytes built from the register settings
`timescale 1ns/1ns
`default_nettype none
module tb_smof_formatter
   import smof_pkg::*;
;
   localparam logic [31:0] VS = 32'h6463_6261, MS = 32'h2a2b_2c2d;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, mv = 0;
   logic [7:0] awa = 0, ara = 0, verd = 0;
   logic [31:0] wd = 0, rd_d, sd = 32'ha82e;
   logic [511:0] vals = 0;
   logic awr, wr_r, bv, arr, rv, txd, busy;
   logic [1:0] br, rr;
   logic [7:0] eq[$];
   int n_fail = 0, num_checks = 0;
   smof_formatter dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rrdy), .meas_valid(mv), .meas_values(vals),
      .fail_verdict(verd), .txd(txd), .busy(busy));
   smof_rx_model #(.DIV(4)) rx (.aclk(aclk), .txd(txd));
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
   endfunction
   function automatic void sep(logic [1:0] m, logic [1:0] n, logic [31:0] u);
      if (m == SEP_TAB) eq.push_back(CH_TAB);
      else if (m == SEP_LF) eq.push_back(CH_LF);
      else for (int i = 0; i <= n; i++) eq.push_back(u[8*i+:8]);
   endfunction
   function automatic void val(logic [31:0] v, logic [31:0] c, int w);
      logic [7:0] d[$];
      if (c[CTRL_BIN]) begin
         for (int i = 3; i >= 0; i--) eq.push_back(v[8*i+:8]);
         return;
      end
      do begin
         d.push_front(CH_ZERO + 8'(v % 10));
         v = v / 10;
      end while (v != 0);
      for (int i = d.size(); i < w; i++) eq.push_back(CH_SPACE);
      foreach (d[i]) eq.push_back(d[i]);
      sep(c[CTRL_VMODE+:2], c[CTRL_VLEN+:2], VS);
   endfunction
   task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic w(logic [7:0] a, logic [31:0] d, logic [1:0] er);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      {awv, wv, brdy} <= 3'b111;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end while (awv && !awr || wv && !wr_r);
      do @(posedge aclk); while (bv !== 1'b1);
      brdy <= 1'b0;
      chk("bresp", br, er);
   endtask
   task automatic r(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
      @(posedge aclk);
      ara <= a;
      {arv, rrdy} <= 2'b11;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge aclk); while (rv !== 1'b1);
      rrdy <= 1'b0;
      chk("rdata", rd_d, ed);
      chk("rresp", rr, er);
   endtask
   task automatic run(logic [31:0] c, int mw, logic [31:0] o, logic [7:0] v8);
      logic [511:0] nv;
      logic [1:0]   cd;
      int           n;
      logic         go;
      cd = c[CTRL_COND+:2];
      n = (c[CTRL_CNT+:4] > 8) ? 8 : c[CTRL_CNT+:4];
      go = cd == COND_ALWAYS || cd == COND_FAIL && v8[c[6:4]] || cd == COND_PASS && !v8[c[6:4]];
      w(OFF_CTRL, c, RESP_OKAY);
      w(OFF_MINW, 32'(mw), RESP_OKAY);
      w(OFF_ORDER, o, RESP_OKAY);
      for (int i = 0; i < 16; i++) begin
         sd = lfsr(sd);
         nv[32*i+:32] = sd >> sd[4:0];
      end
      eq.delete();
      rx.q.delete();
      if (go && c[CTRL_PRE]) sep(c[CTRL_MMODE+:2], c[CTRL_MLEN+:2], MS);
      for (int k = 0; k < n; k++) if (go) val(nv[32*o[4*k+:4]+:32], c, mw);
      if (go && !c[CTRL_PRE]) sep(c[CTRL_MMODE+:2], c[CTRL_MLEN+:2], MS);
      while (eq.size() > CHAR_LIMIT) eq.pop_back();
      @(posedge aclk);
      vals <= nv;
      verd <= v8;
      mv <= 1'b1;
      @(posedge aclk);
      mv <= 1'b0;
      @(posedge aclk);
      chk("busy", busy, go);
      if (go) while (busy === 1'b1) @(posedge aclk);
      else repeat (300) @(posedge aclk);
      // busy drops once the last character is handed over, its frame still runs
      repeat (60) @(posedge aclk);
      chk("count", rx.q.size(), eq.size());
      foreach (eq[i]) chk("char", rx.q[i], eq[i]);
      if (go) r(OFF_STATUS, {16'h0000, 8'(eq.size()), 8'h00}, RESP_OKAY);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial forever #4 aclk = ~aclk;
   initial begin
      repeat (60000) @(posedge aclk);
      n_fail++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      r(OFF_BAUD, 32'h0000_043d, RESP_OKAY);
      r(OFF_ORDER, ORDER_RESET, RESP_OKAY);
      r(8'h40, 32'h0, RESP_SLVERR);
      w(8'h40, 32'h1, RESP_SLVERR);
      w(OFF_BAUD, 32'h4, RESP_OKAY);
      w(OFF_VSEP, VS, RESP_OKAY);
      w(OFF_MSEP, MS, RESP_OKAY);
      run(32'h0001_0000, 12, 32'h5, 8'h0);
      run(32'h0003_c902, 0, 32'h925, 8'h0);
      run(32'h0002_0601, 9, 32'h10, 8'h0);
      run(32'h0001_0034, 0, 32'h6, 8'h08);
      run(32'h0001_0034, 0, 32'h6, 8'hf7);
      run(32'h0001_0068, 0, 32'h7, 8'h40);
      run(32'h0001_0068, 0, 32'h7, 8'hbf);
      run(32'h000f_3200, 30, 32'h9876_5432, 8'h0);
      for (int i = 0; i < 4; i++) begin
         sd = lfsr(sd);
         run(sd & 32'h000f_f57f, int'(sd[23:21]), lfsr(sd), sd[31:24]);
      end
      chk("frame", rx.ferr, 0);
      summarize();
   end
endmodule // tb_smof_formatter
`default_nettype wire
